// File: bench/lpddr_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module lpddr_ctl_model #(
  parameter int BAW = 3
) (
  // command link towards the device
  output var logic ck,
  output var logic cke,
  output var logic cs_n,
  output var logic [3:0] cmd,
  output var logic [BAW-1:0] ba,
  output var logic ap,
  output var logic ab
);
  initial begin
    ck = 1'b0;
    cke = 1'b1;
    cs_n = 1'b1;
    cmd = 4'h0;
    ba = '0;
    ap = 1'b0;
    ab = 1'b0;
  end

  // 20 ns setup before the rise; the caller spaces rises at least 80 ns apart
  task automatic issue(input logic [3:0] c, input logic [BAW-1:0] b, input logic a,
      input logic al, input logic en);
    cke = en;
    cs_n = 1'b0;
    cmd = c;
    ba = b;
    ap = a;
    ab = al;
    #20;
    ck = 1'b1;
  endtask

  // ck stands low between commands; released lines flip so stale values never look held
  always @(posedge ck) begin
    #40;
    ck = 1'b0;
    #20;
    cs_n = 1'b1;
    cmd = ~cmd;
    ba = ~ba;
    ap = ~ap;
    ab = ~ab;
  end
endmodule
`default_nettype wire

// File: bench/test_lpddr2_bank_state_machine.sv
`timescale 1ns/10ps
`default_nettype none
module test_lpddr2_bank_state_machine;
  import lpddr_sm_pkg::*;
  logic clk;
  logic srst;
  logic ck, cke, cs_n, ap, ab;
  logic [3:0] cmd;
  logic [2:0] ba;
  bank_e bank_state [8];
  dev_e dev_state_q;
  logic [2:0] burst_bank_q;
  logic mrr_act_q, cmd_ok_q, cmd_err_q;
  int fails;
  int checked;

  lpddr_bank_fsm #(.NB(8), .BAW(3)) i_dut (
    .clk(clk), .srst(srst), .ck(ck), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba),
    .ap(ap), .ab(ab), .bank_state(bank_state), .dev_state_q(dev_state_q),
    .burst_bank_q(burst_bank_q), .mrr_act_q(mrr_act_q), .cmd_ok_q(cmd_ok_q),
    .cmd_err_q(cmd_err_q)
  );

  lpddr_ctl_model #(.BAW(3)) i_ctl (
    .ck(ck), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba), .ap(ap), .ab(ab)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // sel 8 watches the device-wide state, 0..7 a bank
  function automatic logic [3:0] obs(input int sel);
    if (sel == 8)
      return {1'b0, dev_state_q};
    return bank_state[sel];
  endfunction

  // one command; st is held n cycles from the answer, then nxt (n = 0: st only)
  task automatic send(input logic [3:0] c, input logic [2:0] b, input logic a, al, en, ok,
      input int sel, input logic [3:0] st, input int n, input logic [3:0] nxt);
    int k;
    k = 0;
    i_ctl.issue(c, b, a, al, en);
    while (cmd_ok_q !== 1'b1 && cmd_err_q !== 1'b1 && k < 12) begin
      @(posedge clk);
      #1;
      k++;
    end
    check({6'h00, cmd_ok_q, cmd_err_q}, {6'h00, ok, ~ok});
    check({4'h0, obs(sel)}, {4'h0, st});
    if (n > 0) begin
      // same bank left alone until its timed state ends
      repeat (n - 1) @(posedge clk);
      #1;
      check({4'h0, obs(sel)}, {4'h0, st});
      @(posedge clk);
      #1;
      check({4'h0, obs(sel)}, {4'h0, nxt});
      k += n;
    end
    // rises stay at least 80 ns apart and the hold time is kept
    while (k < 16) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  task automatic t_init();
    send(CMD_RESET, 0, 0, 0, 1, 1, 8, D_RESETTING, 0, D_RESETTING);
    send(CMD_MRR, 0, 0, 0, 1, 1, 8, D_RST_MRR, MRR_CYC, D_READY);
  endtask

  task automatic t_bank();
    send(CMD_ACT, 2, 0, 0, 1, 1, 2, B_ACTIVATING, RCD_CYC, B_ACTIVE);
    send(CMD_RD, 2, 0, 0, 1, 1, 2, B_READING, 0, B_READING);
    check({5'h00, burst_bank_q}, 8'h02);
    // a second read inside the burst restarts the full burst length
    send(CMD_RD, 2, 0, 0, 1, 1, 2, B_READING, BURST_CYC, B_ACTIVE);
    send(CMD_WR, 2, 0, 0, 1, 1, 2, B_WRITING, 0, B_WRITING);
    send(CMD_WR, 2, 0, 0, 1, 1, 2, B_WRITING, 0, B_WRITING);
    // terminate ignores the bank address and ends the latest burst
    send(CMD_BST, 5, 0, 0, 1, 1, 2, B_ACTIVE, 0, B_ACTIVE);
    send(CMD_RD, 2, 1, 0, 1, 1, 2, B_RD_AP, RDAP_CYC, B_IDLE);
    send(CMD_PRE, 5, 0, 0, 1, 1, 5, B_PRECHARGING, RP_CYC, B_IDLE);
  endtask

  task automatic t_other();
    send(CMD_ACT, 0, 0, 0, 1, 1, 0, B_ACTIVATING, RCD_CYC, B_ACTIVE);
    send(CMD_ACT, 1, 0, 0, 1, 1, 1, B_ACTIVATING, RCD_CYC, B_ACTIVE);
    send(CMD_WR, 1, 0, 0, 1, 1, 1, B_WRITING, BURST_CYC, B_ACTIVE);
    send(CMD_MRR, 0, 0, 0, 1, 1, 8, D_MRR, MRR_CYC, D_READY);
    check({7'h00, mrr_act_q}, 8'h01);
    check({4'h0, obs(0)}, {4'h0, B_ACTIVE});
    send(CMD_WR, 1, 1, 0, 1, 1, 1, B_WR_AP, RDAP_CYC, B_IDLE);
    send(CMD_PRE, 0, 0, 1, 1, 1, 1, B_PRECHARGING, RP_CYC, B_IDLE);
    repeat (2) @(posedge clk);
    #1;
    check({4'h0, obs(8)}, {4'h0, D_READY});
    check({4'h0, obs(0)}, {4'h0, B_IDLE});
  endtask

  task automatic t_ref();
    send(CMD_MRR, 0, 0, 0, 1, 1, 8, D_MRR, MRR_CYC, D_READY);
    check({7'h00, mrr_act_q}, 8'h00);
    send(CMD_MRW, 0, 0, 0, 1, 1, 8, D_MRW, MRW_CYC, D_READY);
    send(CMD_REFPB, 3, 0, 0, 1, 1, 3, B_REFRESHING, RFCPB_CYC, B_IDLE);
    send(CMD_REFAB, 0, 0, 0, 1, 1, 6, B_REFRESHING, RFCAB_CYC, B_IDLE);
  endtask

  task automatic t_cke();
    send(CMD_ACT, 4, 0, 0, 0, 0, 4, B_IDLE, 0, B_IDLE);
    send(CMD_ACT, 4, 0, 0, 1, 0, 4, B_IDLE, 0, B_IDLE);
    // exit time of 44 cycles counts from the previous rise
    repeat (40) @(posedge clk);
    #1;
    send(CMD_ACT, 4, 0, 0, 1, 1, 4, B_ACTIVATING, RCD_CYC, B_ACTIVE);
  endtask

  initial begin
    #50000;
    fails++;
    summarize();
  end

  initial begin
    fails = 0;
    checked = 0;
    srst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    @(posedge clk);
    #1;
    check({4'h0, obs(8)}, {4'h0, D_POWER_ON});
    check({4'h0, obs(2)}, {4'h0, B_IDLE});
    t_init();
    t_bank();
    t_other();
    t_ref();
    t_cke();
    summarize();
  end
endmodule
`default_nettype wire

// File: hdl/lpddr_bank.sv
`timescale 1ns/10ps
`default_nettype none
module lpddr_bank import lpddr_sm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // operation decoded for this bank
  input wire bop_e op,
  // bank state
  output var bank_e state_q
);
  bank_e st_d;
  logic ld;
  logic [7:0] len;
  logic [7:0] tmr_q;
  logic [7:0] dwell_q;
  logic col_op;
  logic done;

  assign col_op = op inside {OP_RD, OP_WR, OP_RDA, OP_WRA};
  assign done = (tmr_q == TMR_RST);

  always_comb begin
    st_d = state_q;
    ld = 1'b0;
    len = TMR_RST;
    if (col_op && (state_q inside {B_ACTIVE, B_READING, B_WRITING})) begin
      ld = 1'b1; // [RQ1] [RQ3]
      len = (op inside {OP_RD, OP_WR}) ? BURST_CYC : RDAP_CYC; // [RQ14]
      st_d = (op == OP_RD) ? B_READING : (op == OP_WR) ? B_WRITING :
             (op == OP_RDA) ? B_RD_AP : B_WR_AP;
    end else begin
      unique case (state_q)
        B_IDLE: begin
          if (op == OP_ACT) begin
            st_d = B_ACTIVATING; // [RQ13]
            ld = 1'b1;
            len = RCD_CYC;
          end else if (op == OP_PRE) begin
            st_d = B_PRECHARGING; // [RQ19]
            ld = 1'b1;
            len = RP_CYC;
          end else if (op inside {OP_REFPB, OP_REFAB}) begin
            st_d = B_REFRESHING;
            ld = 1'b1;
            len = (op == OP_REFPB) ? RFCPB_CYC : RFCAB_CYC; // [RQ16]
          end
        end
        B_ACTIVE: begin
          if (op == OP_PRE) begin
            st_d = B_PRECHARGING;
            ld = 1'b1;
            len = RP_CYC;
          end
        end
        B_READING, B_WRITING: if (op == OP_BST || done) st_d = B_ACTIVE; // [RQ5]
        B_ACTIVATING: if (done) st_d = B_ACTIVE; // [RQ11] [RQ13]
        B_PRECHARGING, B_RD_AP, B_WR_AP, B_REFRESHING: if (done) st_d = B_IDLE; // [RQ10]
      endcase
    end
  end

  // state changes only on clock edges, on a decoded op or when the loaded timer ends [RQ23]
  always_ff @(posedge clk) begin
    if (srst)
      state_q <= B_IDLE;
    else
      state_q <= st_d;
  end

  // a loaded length n holds the timed state for exactly n cycles
  always_ff @(posedge clk) begin
    if (srst)
      tmr_q <= TMR_RST;
    else if (ld)
      tmr_q <= len - 8'h01;
    else if (!done)
      tmr_q <= tmr_q - 8'h01;
  end

  always_ff @(posedge clk) begin
    if (srst || st_d != state_q)
      dwell_q <= TMR_RST;
    else if (dwell_q != 8'hFF)
      dwell_q <= dwell_q + 8'h01;
  end

  AST_PRE_LEN: assert property (@(posedge clk) disable iff (srst) // [RQ10] [RQ19]
    (state_q == B_PRECHARGING ##1 state_q == B_IDLE) |-> $past(dwell_q) == RP_CYC - 8'h01)
    else $error("precharge left before tRP");
  AST_ACT_LEN: assert property (@(posedge clk) disable iff (srst) // [RQ11] [RQ13]
    (state_q == B_ACTIVATING ##1 state_q != B_ACTIVATING) |->
      state_q == B_ACTIVE && $past(dwell_q) == RCD_CYC - 8'h01)
    else $error("row activate did not last tRCD");
  AST_AP_LEN: assert property (@(posedge clk) disable iff (srst) // [RQ14]
    ((state_q inside {B_RD_AP, B_WR_AP}) ##1 state_q == B_IDLE) |->
      $past(dwell_q) == RDAP_CYC - 8'h01)
    else $error("auto precharge ended early");
  AST_REF_LEN: assert property (@(posedge clk) disable iff (srst) // [RQ16]
    (state_q == B_REFRESHING ##1 state_q == B_IDLE) |->
      $past(dwell_q) == RFCPB_CYC - 8'h01 || $past(dwell_q) == RFCAB_CYC - 8'h01)
    else $error("refresh length wrong");
endmodule
`default_nettype wire

// File: hdl/lpddr_bank_fsm.sv
// Contract
// RQ1 - READ to a reading bank starts a new burst; bank stays reading.
// RQ2 - Controller writes to a reading bank only after burst end or BST.
// RQ3 - WRITE to a writing bank starts a new burst; bank stays writing.
// RQ4 - Controller reads a writing bank only after burst end or BST.
// RQ5 - BST ends the latest READ/WRITE burst of any bank; bank goes active.
// RQ6 - RESET from power-on starts initialization; needs all banks idle.
// RQ7 - MRR while resetting holds for tMRR, then all banks idle.
// RQ8 - Commands count only with CKE high twice and exit time elapsed.
// RQ9 - Controller never sends an unlisted state and command combination.
// RQ10 - A bank is idle only once precharged and tRP elapsed.
// RQ11 - A bank is active once tRCD elapsed after its row opened.
// RQ12 - Same bank gets no command while precharging, activating or in AP burst.
// RQ13 - Row activate lasts tRCD then active; precharge lasts tRP then idle.
// RQ14 - READ/WRITE with auto precharge holds the bank until tRP, then idle.
// RQ15 - Refresh, MRR, MRW and precharge-all states accept only NOP.
// RQ16 - Per-bank refresh lasts tRFCpb; all-bank refresh lasts tRFCab.
// RQ17 - MRW lasts tMRW then all idle; MRR lasts tMRR, banks keep state.
// RQ18 - Precharge-all ends once tRP met, leaving every bank idle.
// RQ19 - PRECHARGE to an idle bank still imposes full tRP.
// RQ20 - Controller sends only NOP to a bank in an AP burst.
// RQ21 - Other banks accept ACT, READ, WRITE, PRE and BST meanwhile.
// RQ22 - MRR beside activating, active or precharging banks enters MR reading.
// RQ23 - One state register per bank plus device state, clock-edge updated.
`timescale 1ns/10ps
`default_nettype none
module lpddr_bank_fsm import lpddr_sm_pkg::*; #(
  parameter int NB = 8,
  parameter int BAW = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // command link from the controller
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [3:0] cmd,
  input wire logic [BAW-1:0] ba,
  input wire logic ap,
  input wire logic ab,
  // state seen from outside
  output var bank_e bank_state [NB],
  output var dev_e dev_state_q,
  output logic [BAW-1:0] burst_bank_q,
  output logic mrr_act_q,
  output logic cmd_ok_q,
  output logic cmd_err_q
);
  if (NB < 2 || NB != (1 << BAW)) begin : g_chk
    $error("NB must equal two to the power BAW");
  end

  localparam int SW = BAW + 9;
  localparam int MRR_DLY = int'(MRR_CYC);
  localparam int MRW_DLY = int'(MRW_CYC);
  localparam int PRE_WAIT = int'(RP_CYC) + 1;
  localparam int REFAB_WAIT = int'(RFCAB_CYC) + 1;

  logic [SW-1:0] sy;
  logic ck_s;
  logic cke_s;
  logic cs_n_s;
  logic [3:0] cmd_s;
  logic [BAW-1:0] ba_s;
  logic ap_s;
  logic ab_s;

  // the link clock is sampled like data; CA is taken on its rising edge only
  lpddr_sync #(.W(SW)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({ck, cke, cs_n, cmd, ba, ap, ab}),
    .q(sy)
  );
  assign {ck_s, cke_s, cs_n_s, cmd_s, ba_s, ap_s, ab_s} = sy;

  logic ck_prev_q;
  logic rise;

  always_ff @(posedge clk) begin
    if (srst)
      ck_prev_q <= FLAG_RST;
    else
      ck_prev_q <= ck_s;
  end
  assign rise = ck_s && !ck_prev_q;

  logic cke_prev_q;
  logic [7:0] exit_tmr_q;
  logic cke_ok;

  always_ff @(posedge clk) begin
    if (srst)
      cke_prev_q <= CKE_PREV_RST;
    else if (rise)
      cke_prev_q <= cke_s;
  end

  // one exit time for both power-down and self refresh; the longer one is
  // used since entry into either lies outside this block
  always_ff @(posedge clk) begin
    if (srst)
      exit_tmr_q <= TMR_RST;
    else if (rise && cke_s && !cke_prev_q)
      exit_tmr_q <= XSR_CYC; // [RQ8]
    else if (exit_tmr_q != TMR_RST)
      exit_tmr_q <= exit_tmr_q - 8'h01;
  end
  assign cke_ok = cke_s && cke_prev_q && (exit_tmr_q == TMR_RST); // [RQ8]

  logic cmd_seen;
  logic legal;
  logic accept;

  assign cmd_seen = rise && !cs_n_s && (cmd_s != CMD_NOP);

  logic all_idle;
  logic all_mrr_ok;
  logic all_pre_ok;
  logic any_active;

  always_comb begin
    all_idle = 1'b1;
    all_mrr_ok = 1'b1;
    all_pre_ok = 1'b1;
    any_active = 1'b0;
    for (int i = 0; i < NB; i++) begin
      if (bank_state[i] != B_IDLE)
        all_idle = 1'b0;
      if (!(bank_state[i] inside {B_IDLE, B_ACTIVATING, B_ACTIVE, B_PRECHARGING}))
        all_mrr_ok = 1'b0;
      if (!(bank_state[i] inside {B_IDLE, B_ACTIVE, B_PRECHARGING}))
        all_pre_ok = 1'b0;
      if (bank_state[i] inside {B_ACTIVATING, B_ACTIVE})
        any_active = 1'b1;
    end
  end

  logic [BAW-1:0] tgt;
  bank_e tgt_st;

  // burst terminate ignores the bank address and hits the latest burst
  assign tgt = (cmd_s == CMD_BST) ? burst_bank_q : ba_s; // [RQ5]
  assign tgt_st = bank_state[tgt];

  // busy banks refuse everything aimed at them
  function automatic logic bank_ok(input bank_e s, input logic [3:0] c);
    logic ok;
    ok = 1'b0;
    case (c)
      CMD_ACT: ok = (s == B_IDLE);
      CMD_RD, CMD_WR: ok = (s inside {B_ACTIVE, B_READING, B_WRITING});
      CMD_PRE: ok = (s inside {B_IDLE, B_ACTIVE});
      CMD_REFPB: ok = (s == B_IDLE);
      CMD_BST: ok = (s inside {B_READING, B_WRITING});
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  always_comb begin
    legal = 1'b0;
    unique case (dev_state_q)
      D_POWER_ON: legal = (cmd_s == CMD_RESET) && all_idle; // [RQ6]
      D_RESETTING: legal = (cmd_s == CMD_MRR); // [RQ7]
      D_READY: begin
        case (cmd_s)
          CMD_MRR: legal = all_mrr_ok; // [RQ22]
          CMD_MRW, CMD_REFAB, CMD_RESET: legal = all_idle;
          CMD_PRE: legal = ab_s ? all_pre_ok : bank_ok(tgt_st, cmd_s);
          default: legal = bank_ok(tgt_st, cmd_s); // [RQ12] [RQ20] [RQ21]
        endcase
      end
      D_RST_MRR, D_MRR, D_MRW, D_REFAB, D_PREALL: legal = 1'b0; // [RQ15]
    endcase
  end

  // an unlisted combination is refused and flagged, never acted on
  assign accept = cmd_seen && cke_ok && legal; // [RQ9]

  bop_e gop;
  logic all_op;

  always_comb begin
    gop = OP_NONE;
    all_op = 1'b0;
    case (cmd_s)
      CMD_ACT: gop = OP_ACT;
      CMD_RD: gop = ap_s ? OP_RDA : OP_RD;
      CMD_WR: gop = ap_s ? OP_WRA : OP_WR;
      CMD_PRE: begin
        gop = OP_PRE;
        all_op = ab_s;
      end
      CMD_REFPB: gop = OP_REFPB;
      CMD_REFAB: begin
        gop = OP_REFAB;
        all_op = 1'b1;
      end
      CMD_BST: gop = OP_BST;
      default: gop = OP_NONE;
    endcase
  end

  bop_e bop [NB];

  for (genvar i = 0; i < NB; i++) begin : g_bank
    assign bop[i] = (accept && (all_op || tgt == BAW'(i))) ? gop : OP_NONE; // [RQ21]
    lpddr_bank u_bank ( // [RQ23]
      .clk(clk),
      .srst(srst),
      .op(bop[i]),
      .state_q(bank_state[i])
    );
  end

  logic [7:0] dev_tmr_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      dev_state_q <= D_POWER_ON;
      dev_tmr_q <= TMR_RST;
    end else begin
      if (dev_tmr_q != TMR_RST)
        dev_tmr_q <= dev_tmr_q - 8'h01;
      unique case (dev_state_q)
        D_POWER_ON: if (accept) dev_state_q <= D_RESETTING; // [RQ6]
        D_RESETTING: begin
          if (accept) begin
            dev_state_q <= D_RST_MRR; // [RQ7]
            dev_tmr_q <= MRR_CYC - 8'h01;
          end
        end
        D_READY: begin
          if (accept) begin
            case (cmd_s)
              CMD_MRR: begin
                dev_state_q <= D_MRR; // [RQ22]
                dev_tmr_q <= MRR_CYC - 8'h01;
              end
              CMD_MRW: begin
                dev_state_q <= D_MRW; // [RQ17]
                dev_tmr_q <= MRW_CYC - 8'h01;
              end
              CMD_REFAB: dev_state_q <= D_REFAB; // [RQ16]
              CMD_RESET: dev_state_q <= D_RESETTING;
              CMD_PRE: if (ab_s) dev_state_q <= D_PREALL; // [RQ18]
              default: dev_state_q <= D_READY;
            endcase
          end
        end
        D_RST_MRR, D_MRR, D_MRW: if (dev_tmr_q == TMR_RST) dev_state_q <= D_READY; // [RQ17]
        // banks time themselves; the device waits until all have settled
        D_REFAB, D_PREALL: if (all_idle) dev_state_q <= D_READY; // [RQ18]
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst)
      burst_bank_q <= '0;
    else if (accept && (cmd_s == CMD_RD || cmd_s == CMD_WR))
      burst_bank_q <= ba_s; // [RQ5]
  end

  // tells an active-bank MRR from an idle one
  always_ff @(posedge clk) begin
    if (srst)
      mrr_act_q <= FLAG_RST;
    else if (accept && cmd_s == CMD_MRR)
      mrr_act_q <= any_active; // [RQ22]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_ok_q <= FLAG_RST;
      cmd_err_q <= FLAG_RST;
    end else begin
      cmd_ok_q <= accept;
      cmd_err_q <= cmd_seen && !accept;
    end
  end

  AST_READ_RESTART: assert property (@(posedge clk) disable iff (srst) // [RQ1]
    accept && cmd_s == CMD_RD && tgt_st == B_READING |=>
      bank_state[$past(ba_s)] inside {B_READING, B_RD_AP})
    else $error("read to reading bank did not restart burst");

  AST_WRITE_RESTART: assert property (@(posedge clk) disable iff (srst) // [RQ3]
    accept && cmd_s == CMD_WR && tgt_st == B_WRITING |=>
      bank_state[$past(ba_s)] inside {B_WRITING, B_WR_AP})
    else $error("write to writing bank did not restart burst");

  AST_BST_ENDS: assert property (@(posedge clk) disable iff (srst) // [RQ5]
    accept && cmd_s == CMD_BST |=> bank_state[$past(burst_bank_q)] == B_ACTIVE)
    else $error("burst terminate left the bank bursting");

  AST_RESET_START: assert property (@(posedge clk) disable iff (srst) // [RQ6]
    dev_state_q == D_POWER_ON && accept |-> all_idle ##1 dev_state_q == D_RESETTING)
    else $error("reset did not enter resetting");

  AST_RST_MRR_LEN: assert property (@(posedge clk) disable iff (srst) // [RQ7]
    $rose(dev_state_q == D_RST_MRR) |->
      ##MRR_DLY dev_state_q == D_READY && all_idle)
    else $error("resetting MRR length wrong");

  AST_CKE_GATE: assert property (@(posedge clk) disable iff (srst) // [RQ8]
    cmd_ok_q |-> $past(cke_s) && $past(cke_prev_q) && $past(exit_tmr_q) == TMR_RST)
    else $error("command taken without CKE or before exit time");

  AST_BUSY_REFUSE: assert property (@(posedge clk) disable iff (srst) // [RQ15]
    (dev_state_q inside {D_RST_MRR, D_MRR, D_MRW, D_REFAB, D_PREALL}) && cmd_seen
      |=> cmd_err_q && !cmd_ok_q)
    else $error("command taken in a NOP-only state");

  AST_REFAB_END: assert property (@(posedge clk) disable iff (srst) // [RQ16]
    $rose(dev_state_q == D_REFAB) |-> ##[1:REFAB_WAIT] dev_state_q == D_READY)
    else $error("all-bank refresh overran");

  AST_MRW_LEN: assert property (@(posedge clk) disable iff (srst) // [RQ17]
    $rose(dev_state_q == D_MRW) |-> ##MRW_DLY dev_state_q == D_READY)
    else $error("mode register write length wrong");

  AST_PREALL_END: assert property (@(posedge clk) disable iff (srst) // [RQ18]
    $rose(dev_state_q == D_PREALL) |-> ##[1:PRE_WAIT] (dev_state_q == D_READY && all_idle))
    else $error("precharge all overran");

  AST_OTHER_ACT: assert property (@(posedge clk) disable iff (srst) // [RQ21]
    accept && cmd_s == CMD_ACT |=> bank_state[$past(ba_s)] == B_ACTIVATING)
    else $error("activate to a free bank not taken");

  AST_MRR_ENTRY: assert property (@(posedge clk) disable iff (srst) // [RQ22]
    accept && cmd_s == CMD_MRR && dev_state_q == D_READY |=>
      dev_state_q == D_MRR ##MRR_DLY dev_state_q == D_READY)
    else $error("mode register read state wrong");
endmodule
`default_nettype wire

// File: hdl/lpddr_sm_pkg.sv
package lpddr_sm_pkg;
  localparam int CLK_PS = 5000;
  // core timings in ns, plain defaults
  localparam int T_RP_NS = 18;
  localparam int T_RCD_NS = 18;
  localparam int T_RFCPB_NS = 90;
  localparam int T_RFCAB_NS = 210;
  localparam int T_MRR_NS = 10;
  localparam int T_MRW_NS = 10;
  // spans more than one link period so a restart or terminate can land inside it
  localparam int T_BURST_NS = 200;
  localparam int T_XSR_NS = 220;

  // least times round up, never below one cycle
  function automatic logic [7:0] ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    if (c < 1)
      c = 1;
    return c[7:0];
  endfunction

  localparam logic [7:0] RP_CYC = ns_to_cyc(T_RP_NS);
  localparam logic [7:0] RCD_CYC = ns_to_cyc(T_RCD_NS);
  localparam logic [7:0] RFCPB_CYC = ns_to_cyc(T_RFCPB_NS);
  localparam logic [7:0] RFCAB_CYC = ns_to_cyc(T_RFCAB_NS);
  localparam logic [7:0] MRR_CYC = ns_to_cyc(T_MRR_NS);
  localparam logic [7:0] MRW_CYC = ns_to_cyc(T_MRW_NS);
  localparam logic [7:0] BURST_CYC = ns_to_cyc(T_BURST_NS);
  localparam logic [7:0] RDAP_CYC = ns_to_cyc(T_BURST_NS + T_RP_NS);
  localparam logic [7:0] XSR_CYC = ns_to_cyc(T_XSR_NS);

  localparam logic [7:0] TMR_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic CKE_PREV_RST = 1'b1;

  // decoded command codes on the cmd port
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_ACT = 4'h1;
  localparam logic [3:0] CMD_RD = 4'h2;
  localparam logic [3:0] CMD_WR = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h4;
  localparam logic [3:0] CMD_REFPB = 4'h5;
  localparam logic [3:0] CMD_REFAB = 4'h6;
  localparam logic [3:0] CMD_MRW = 4'h7;
  localparam logic [3:0] CMD_MRR = 4'h8;
  localparam logic [3:0] CMD_RESET = 4'h9;
  localparam logic [3:0] CMD_BST = 4'hA;

  typedef enum logic [3:0] {
    B_IDLE, B_ACTIVATING, B_ACTIVE, B_READING, B_WRITING,
    B_RD_AP, B_WR_AP, B_PRECHARGING, B_REFRESHING
  } bank_e;

  typedef enum logic [2:0] {
    D_POWER_ON, D_RESETTING, D_RST_MRR, D_READY,
    D_MRR, D_MRW, D_REFAB, D_PREALL
  } dev_e;

  typedef enum logic [3:0] {
    OP_NONE, OP_ACT, OP_RD, OP_WR, OP_RDA, OP_WRA,
    OP_PRE, OP_REFPB, OP_REFAB, OP_BST
  } bop_e;
endpackage

// File: hdl/lpddr_sync.sv
`timescale 1ns/10ps
`default_nettype none
module lpddr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  if (W < 1) begin : g_chk
    $error("W must be at least one");
  end

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire
